// File: design/flash_self_program_sequencer.v
// flash self-programming sequencer with ahb-lite register slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.vh"
module flash_self_program_sequencer #(
    parameter ROW_WRITE_CYCLES  = `ROW_WRITE_CYCLES,
    parameter PAGE_ERASE_CYCLES = `PAGE_ERASE_CYCLES,
    parameter WORD_WRITE_CYCLES = `WORD_WRITE_CYCLES,
    parameter WORD_WIDTH        = 24
) (
    // clock and reset
    input  wire                  hclk,
    input  wire                  hresetn,
    // ahb-lite slave
    input  wire                  hsel,
    input  wire [11:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output wire                  hreadyout,
    output wire                  hresp,
    output reg  [31:0]           hrdata,
    // core stall
    output wire                  core_stall,
    // flash array side
    output reg                   flash_prog_en,
    output reg                   flash_erase_en,
    output reg  [15:0]           flash_addr,
    output wire [WORD_WIDTH-1:0] flash_wdata
);
    // ------------------------------------------------------------
    // state and register storage
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_RUN  = 2'b01;
    localparam ST_DONE = 2'b10;
    localparam KEY_NONE = 2'b00;
    localparam KEY_HALF = 2'b01;
    localparam KEY_OPEN = 2'b10;

    reg  [1:0]            state_reg;
    reg  [1:0]            key_reg;
    reg  [3:0]            op_reg;
    reg                   err_reg;
    reg  [`TUNE_WIDTH-1:0] tune_reg;
    reg  [15:0]           addr_reg;
    reg  [5:0]            buf_ptr_reg;
    reg  [23:0]           osc_acc_reg;
    reg  [15:0]           osc_cnt_reg;
    reg  [15:0]           osc_target_reg;
    reg                   dph_write_reg;
    reg                   dph_read_reg;
    reg  [11:0]           dph_addr_reg;
    wire                  osc_tick;
    wire [24:0]           acc_sum;
    wire [`TUNE_WIDTH-1:0] tune_step;
    wire [WORD_WIDTH-1:0] buf_rdata;

    // ------------------------------------------------------------
    // bus slave: zero wait states, always okay
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    wire   addr_ok   = hsel & hready & htrans[1];

    // capture the address phase for use in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_write_reg <= 1'b0;
            dph_read_reg  <= 1'b0;
            dph_addr_reg  <= 12'h000;
        end else begin
            dph_write_reg <= addr_ok & hwrite;
            dph_read_reg  <= addr_ok & ~hwrite;
            dph_addr_reg  <= haddr;
        end
    end

    wire wr_ctrl = dph_write_reg & (dph_addr_reg == `OFS_CONTROL);
    wire wr_key  = dph_write_reg & (dph_addr_reg == `OFS_KEY);
    wire wr_tune = dph_write_reg & (dph_addr_reg == `OFS_TUNING);
    wire wr_addr = dph_write_reg & (dph_addr_reg == `OFS_ADDRESS);
    wire wr_buf  = dph_write_reg & (dph_addr_reg == `OFS_BUFFER);
    wire busy    = (state_reg == ST_RUN);
    wire start_req = wr_ctrl & hwdata[`CTRL_START_BIT];

    // ------------------------------------------------------------
    // unlock key tracking
    // ------------------------------------------------------------
    // any write other than the next key value drops the unlock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_reg <= KEY_NONE;
        end else if (dph_write_reg) begin
            if (wr_key && hwdata[7:0] == `KEY_FIRST) begin
                key_reg <= KEY_HALF; // [RL4]
            end else if (wr_key && key_reg == KEY_HALF && hwdata[7:0] == `KEY_SECOND) begin
                key_reg <= KEY_OPEN; // [RL4]
            end else begin
                key_reg <= KEY_NONE; // [RL14]
            end
        end
    end

    // ------------------------------------------------------------
    // control, tuning, address and buffer pointer registers
    // ------------------------------------------------------------
    // writes are refused while busy; the core is stalled then anyway
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_reg      <= 4'h0;
            err_reg     <= 1'b0;
            tune_reg    <= `TUNE_RESET;
            addr_reg    <= 16'h0000;
            buf_ptr_reg <= 6'h00;
        end else if (!busy) begin
            if (wr_ctrl) begin
                op_reg  <= hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]; // [RL6]
                err_reg <= start_req & (key_reg != KEY_OPEN);
            end
            if (wr_tune) begin
                tune_reg <= hwdata[`TUNE_WIDTH-1:0]; // [RL9]
            end
            if (wr_addr) begin
                addr_reg    <= hwdata[15:0];
                buf_ptr_reg <= 6'h00; // [RL12]
            end else if (wr_buf) begin
                buf_ptr_reg <= buf_ptr_reg + 6'h01; // [RL12]
            end
        end
    end

    // ------------------------------------------------------------
    // holding buffer
    // ------------------------------------------------------------
    row_buffer_mem #(
        .WIDTH (WORD_WIDTH),
        .DEPTH (`ROW_WORDS),
        .AW    (6)
    ) u_row_buffer (
        .hclk    (hclk),
        .wr_en   (wr_buf & ~busy),
        .wr_addr (buf_ptr_reg),
        .wr_data (hwdata[WORD_WIDTH-1:0]),
        .rd_addr (osc_cnt_reg[5:0]),
        .rd_data (buf_rdata)
    );
    assign flash_wdata = buf_rdata;

    // ------------------------------------------------------------
    // oscillator tick generator
    // ------------------------------------------------------------
    // phase accumulator yields the rc rate from hclk; tuning trims the step
    // by one khz of step per code, a signed six-bit offset
    assign tune_step = tune_reg;
    wire [23:0] osc_step = `OSC_KHZ + {{18{tune_step[`TUNE_WIDTH-1]}}, tune_step}; // [RL7]
    assign acc_sum  = {1'b0, osc_acc_reg} + {1'b0, osc_step};
    wire [24:0] acc_wrap = acc_sum - `CLK_KHZ;
    assign osc_tick = (acc_sum >= `CLK_KHZ);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_acc_reg <= 24'h000000;
        end else if (!busy) begin
            osc_acc_reg <= 24'h000000;
        end else if (osc_tick) begin
            osc_acc_reg <= acc_wrap[23:0]; // [RL7]
        end else begin
            osc_acc_reg <= acc_sum[23:0];
        end
    end

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    wire op_valid = (op_reg == `OP_ROW_PROGRAM) | (op_reg == `OP_PAGE_ERASE) |
                    (op_reg == `OP_WORD_PROGRAM);
    wire launch = start_req & (key_reg == KEY_OPEN) &
                  (hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] != 4'h0); // [RL1]

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg      <= ST_IDLE;
            osc_cnt_reg    <= 16'h0000;
            osc_target_reg <= 16'h0000;
            flash_prog_en  <= 1'b0;
            flash_erase_en <= 1'b0;
            flash_addr     <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    osc_cnt_reg <= 16'h0000;
                    if (launch) begin // [RL3]
                        state_reg <= ST_RUN;
                        if (hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_PAGE_ERASE) begin
                            osc_target_reg <= PAGE_ERASE_CYCLES[15:0];
                            flash_erase_en <= 1'b1;
                            // page aligned address, rounded down to a multiple of PAGE_BYTES [RL11]
                            flash_addr <= addr_reg - (addr_reg % `PAGE_BYTES);
                        end else if (hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_WORD_PROGRAM) begin
                            osc_target_reg <= WORD_WRITE_CYCLES[15:0];
                            flash_prog_en  <= 1'b1;
                            flash_addr     <= addr_reg;
                        end else begin
                            osc_target_reg <= ROW_WRITE_CYCLES[15:0]; // [RL8]
                            flash_prog_en  <= 1'b1;
                            // one row per launch [RL10] [RL13]
                            flash_addr <= addr_reg - (addr_reg % `ROW_BYTES);
                        end
                    end
                end
                ST_RUN: begin
                    if (osc_tick) begin
                        osc_cnt_reg <= osc_cnt_reg + 16'h0001; // [RL7]
                        if (osc_cnt_reg + 16'h0001 >= osc_target_reg) begin
                            // array released first, core one cycle later
                            state_reg      <= ST_DONE; // [RL8]
                            flash_prog_en  <= 1'b0;
                            flash_erase_en <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    flash_prog_en  <= 1'b0;
                    flash_erase_en <= 1'b0;
                    state_reg      <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // the core waits for the whole operation and its wrap-up cycle
    assign core_stall = (state_reg != ST_IDLE); // [RL2]

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok & ~hwrite) begin
            case (haddr)
                `OFS_CONTROL: hrdata <= {16'h0000, core_stall, 1'b0, err_reg, 9'h000,
                                         op_reg}; // [RL3]
                `OFS_KEY:     hrdata <= 32'h00000000; // [RL5]
                `OFS_TUNING:  hrdata <= {26'h0000000, tune_reg};
                `OFS_ADDRESS: hrdata <= {16'h0000, addr_reg};
                `OFS_STATUS:  hrdata <= {16'h0000, osc_cnt_reg};
                default:      hrdata <= 32'h00000000;
            endcase
        end
    end

    wire unused_ok = &{1'b0, hsize, dph_read_reg, op_valid, `CTRL_MASK};
endmodule // flash_self_program_sequencer
`default_nettype wire

// File: design/flash_seq_defs.vh
// constants for the flash self-programming sequencer
//
// Summary of operation
// (RL1) only a complete unlock-then-start sequence launches an erase or program
// (RL2) the core is held stalled while an operation runs, released at its end
// (RL3) start bit 15 launches the operation and clears itself when done
// (RL4) key writes 0x55 then 0xAA, consecutively, must precede the start
// (RL5) key register is write-only and reads back as zero
// (RL6) control register holds erase block select, memory type and start trigger
// (RL7) operations are timed in cycles of the internal fast rc oscillator
// (RL8) a row write lasts 11064 oscillator cycles
// (RL9) tuning field is six bits; its setting scales the oscillator rate
// (RL10) a row is 64 instruction words, 192 bytes, the row program unit
// (RL11) erase clears one page of eight rows, aligned on 1536 bytes
// (RL12) holding buffer of 64 words is filled by aligned sequential table writes
// (RL13) each row needs its own separately launched programming cycle
// (RL14) a start without the directly preceding key pair is ignored
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CONTROL      12'h000
`define OFS_KEY          12'h004
`define OFS_TUNING       12'h008
`define OFS_ADDRESS      12'h00C
`define OFS_BUFFER       12'h010
`define OFS_STATUS       12'h014

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_START_BIT   15
`define CTRL_ERR_BIT     13
`define CTRL_OP_LSB      0
`define CTRL_OP_MSB      3
`define CTRL_MASK        16'h000F
`define OP_ROW_PROGRAM   4'h1
`define OP_PAGE_ERASE    4'h2
`define OP_WORD_PROGRAM  4'h3

// ------------------------------------------------------------
// unlock key values
// ------------------------------------------------------------
`define KEY_FIRST        8'h55
`define KEY_SECOND       8'hAA

// ------------------------------------------------------------
// geometry and timing
// ------------------------------------------------------------
`define ROW_WORDS        64
`define ROW_BYTES        16'h00C0
`define PAGE_ROWS        8
`define PAGE_BYTES       16'h0600
`define TUNE_WIDTH       6
`define TUNE_RESET       6'h00
`define ROW_WRITE_CYCLES 11064
`define PAGE_ERASE_CYCLES 11064
`define WORD_WRITE_CYCLES 1680
`define OSC_KHZ          24'h001CCA
`define CLK_KHZ          25'h000C350

`endif

// File: design/row_buffer_mem.v
// holding buffer memory for one flash row of instruction words
`timescale 1ns/1ps
`default_nettype none
module row_buffer_mem #(
    parameter WIDTH = 24,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    // clock
    input  wire             hclk,
    // write port
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    // read port, data registered
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // no reset on the array: contents are undefined until software loads them
    always @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // row_buffer_mem
`default_nettype wire

// File: testbench/flash_seq_props.sv
// checker for the flash sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.vh"
module flash_seq_props #(
    parameter ROW_WRITE_CYCLES  = 8,
    parameter PAGE_ERASE_CYCLES = 8,
    parameter WORD_WRITE_CYCLES = 8,
    parameter WORD_WIDTH        = 24
) (
    // clock and reset
    input wire logic                  hclk,
    input wire logic                  hresetn,
    // ahb-lite slave
    input wire logic                  hsel,
    input wire logic [11:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    // core and flash side
    input wire logic                  core_stall,
    input wire logic                  flash_prog_en,
    input wire logic                  flash_erase_en,
    input wire logic [15:0]           flash_addr,
    input wire logic [WORD_WIDTH-1:0] flash_wdata
);
    // --------------------------------
    // bus tracking
    // --------------------------------
    localparam int MINC = WORD_WRITE_CYCLES * 5;
    localparam int MAXC = (ROW_WRITE_CYCLES + PAGE_ERASE_CYCLES) * 9 + 4;
    logic        dp_wr, dp_rd, start_ok;
    logic [11:0] dp_addr;
    logic [1:0]  key_st;
    int          stall_n;
    // the key pair only counts if no other write slips in between
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 12'h000;
            start_ok <= 1'b0;
            key_st <= 2'h0;
            stall_n <= 0;
        end else begin
            dp_wr <= hsel && hready && htrans[1] && hwrite;
            dp_rd <= hsel && hready && htrans[1] && !hwrite;
            dp_addr <= haddr;
            start_ok <= dp_wr && dp_addr == `OFS_CONTROL && hwdata[15]
                        && hwdata[3:0] != 4'h0 && key_st == 2'h2 && !core_stall;
            if (dp_wr)
                key_st <= (dp_addr == `OFS_KEY && hwdata[7:0] == `KEY_FIRST) ? 2'h1 :
                          (dp_addr == `OFS_KEY && hwdata[7:0] == `KEY_SECOND
                           && key_st == 2'h1) ? 2'h2 : 2'h0;
            stall_n <= core_stall ? stall_n + 1 : 0;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_start_needs_key: assert property ($rose(core_stall) |-> start_ok)
        else $error("stall rose without an unlocked start");
    a_start_launches: assert property (start_ok |-> core_stall ##[0:1]
        (flash_prog_en || flash_erase_en))
        else $error("unlocked start did not launch");
    a_stall_covers_op: assert property ((flash_prog_en || flash_erase_en) |-> core_stall)
        else $error("flash busy while core released");
    a_release_after_done: assert property ($fell(flash_prog_en || flash_erase_en)
        |-> core_stall ##1 !core_stall)
        else $error("core release not one cycle after op end");
    a_single_op_kind: assert property (!(flash_prog_en && flash_erase_en))
        else $error("program and erase together");
    a_stall_bounded: assert property (core_stall |-> stall_n <= MAXC)
        else $error("operation ran too long");
    a_stall_min_len: assert property ($fell(core_stall) |-> $past(stall_n) >= MINC)
        else $error("operation ended too early");
    a_key_reads_zero: assert property (dp_rd && dp_addr == `OFS_KEY |-> hrdata == 32'h0)
        else $error("key register read nonzero");
    cover property ($rose(flash_prog_en));
    cover property ($rose(flash_erase_en));
    cover property (dp_wr && dp_addr == `OFS_CONTROL && hwdata[15] && key_st != 2'h2);
endmodule // flash_seq_props
bind flash_self_program_sequencer flash_seq_props #(
    .ROW_WRITE_CYCLES(ROW_WRITE_CYCLES), .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES),
    .WORD_WRITE_CYCLES(WORD_WRITE_CYCLES), .WORD_WIDTH(WORD_WIDTH)
) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_stall(core_stall),
    .flash_prog_en(flash_prog_en), .flash_erase_en(flash_erase_en),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata)
);
`default_nettype wire

// File: testbench/flash_array_model.sv
// flash array model that tallies launched operations
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // operation strobes
    input wire logic        prog_en,
    input wire logic        erase_en,
    // tallies
    output var logic [7:0]  n_prog,
    output var logic [7:0]  n_erase
);
    logic prog_q, erase_q;
    // each launch counts once, so merged cycles would show as a short tally
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            n_prog <= 8'h00;
            n_erase <= 8'h00;
        end else begin
            prog_q <= prog_en;
            erase_q <= erase_en;
            if (prog_en && !prog_q) n_prog <= n_prog + 8'h01;
            if (erase_en && !erase_q) n_erase <= n_erase + 8'h01;
        end
    end
endmodule // flash_array_model
`default_nettype wire

// File: testbench/flash_self_program_sequencer_tb_top.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.vh"
module flash_self_program_sequencer_tb_top;
    localparam int OPC = 8; // short counts keep the run brief
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd, v, b0, seed = 32'h6;
    logic [15:0] fa;
    logic [23:0] fw;
    logic hreadyout, hresp, core_stall, prog_en, erase_en;
    logic [7:0]  n_prog, n_erase, ep = 8'h00, ee = 8'h00;
    logic [3:0]  op;
    int n_errors = 0, check_count = 0, n;
    always #10 hclk = ~hclk;
    flash_self_program_sequencer #(.ROW_WRITE_CYCLES(OPC), .PAGE_ERASE_CYCLES(OPC),
        .WORD_WRITE_CYCLES(OPC), .WORD_WIDTH(24)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_stall(core_stall),
        .flash_prog_en(prog_en), .flash_erase_en(erase_en), .flash_addr(fa),
        .flash_wdata(fw));
    flash_array_model u_flash (.hclk(hclk), .hresetn(hresetn), .prog_en(prog_en),
        .erase_en(erase_en), .n_prog(n_prog), .n_erase(n_erase));
    // --------------------------------
    // helpers
    // --------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {program, erase} strobes for an operation code
    function logic [1:0] exp_en(input logic [3:0] c);
        return (c == `OP_PAGE_ERASE) ? 2'b01 : 2'b10;
    endfunction
    // expected target: page or row aligned, a single word as given
    function logic [15:0] exp_addr(input logic [3:0] c, input logic [15:0] a);
        if (c == `OP_PAGE_ERASE) return a - a % `PAGE_BYTES;
        if (c == `OP_ROW_PROGRAM) return a - a % `ROW_BYTES;
        return a;
    endfunction
    task print_verdict;
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            print_verdict;
        end
    endtask
    // one single transfer; entered just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
        chk(hresp, 0);
    endtask
    task unlock;
        xfer(1, `OFS_KEY, 32'h55);
        xfer(1, `OFS_KEY, 32'hAA);
    endtask
    // start an operation, then check launch or refusal and its length
    task launch(input logic [3:0] c, input logic ok);
        xfer(1, `OFS_CONTROL, {16'h0, 1'b1, 11'h0, c});
        @(posedge hclk);
        @(posedge hclk);
        chk(core_stall, ok);
        chk({prog_en, erase_en}, ok ? exp_en(c) : 2'b00);
        n = 0;
        while (core_stall === 1'b1 && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        if (core_stall !== 1'b0) begin
            n_errors++;
            print_verdict;
        end
        if (ok) chk(n >= OPC * 5, 1);
        xfer(0, `OFS_CONTROL, 32'h0);
        chk(rd[15], 0);
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, `OFS_KEY, 0);
        chk(rd, 0);
        xfer(0, 12'hFF0, 0);
        chk(rd, 0);
        launch(`OP_ROW_PROGRAM, 0);
        chk(rd[13], 1);
        // key pair broken by another write, then pair spent by one
        xfer(1, `OFS_KEY, 32'h55);
        xfer(1, `OFS_TUNING, 0);
        xfer(1, `OFS_KEY, 32'hAA);
        launch(`OP_PAGE_ERASE, 0);
        unlock;
        xfer(1, `OFS_ADDRESS, 0);
        launch(`OP_ROW_PROGRAM, 0);
        // tuning field keeps six bits only
        repeat (4) begin
            v = rnd();
            xfer(1, `OFS_TUNING, v);
            xfer(0, `OFS_TUNING, 0);
            chk(rd, {26'h0, v[5:0]});
        end
        xfer(1, `OFS_TUNING, 0);
        // every operation kind, each row launched on its own
        for (int i = 0; i < 6; i++) begin
            op = 4'(i % 3 + 1);
            v = rnd() & 32'h0000FFFF;
            b0 = rnd() & 32'h00FFFFFF;
            xfer(1, `OFS_ADDRESS, v);
            xfer(1, `OFS_BUFFER, b0);
            repeat (`ROW_WORDS - 1) xfer(1, `OFS_BUFFER, rnd() & 32'h00FFFFFF);
            unlock;
            launch(op, 1);
            chk(fa, exp_addr(op, v[15:0]));
            chk(fw, b0);
            if (op == `OP_PAGE_ERASE) ee++;
            else ep++;
        end
        launch(`OP_WORD_PROGRAM, 0);
        chk(n_prog, ep);
        chk(n_erase, ee);
        print_verdict;
    end
endmodule // flash_self_program_sequencer_tb_top
`default_nettype wire
